// *** hw/gpb_params.svh ***
// Constants for the four-bit general purpose port block
// Function
// RULE_01: Four bidirectional pins, each with direction, latch and analog-select bits.
// RULE_02: Direction bit one disables the pin driver; pin is an input.
// RULE_03: Direction bit zero enables the driver, driving the latch bit.
// RULE_04: Port data read returns pin levels; a write updates the latch.
// RULE_05: Port writes are read-modify-write: sample pins, merge, store into latch.
// RULE_06: Direction bits govern drivers regardless of analog select.
// RULE_07: Analog-select one makes digital reads of that pin return zero.
// RULE_08: Analog select never affects output; an analog output pin keeps driving.
// RULE_09: After reset all analog-select bits are set; software clears them.
// RULE_10: Latch register reads stored bits; unimplemented upper bits read zero.
`ifndef GPB_PARAMS_SVH
`define GPB_PARAMS_SVH
`define GPB_PIN_COUNT 4
`define GPB_OFS_PORT 8'h00
`define GPB_OFS_DIR 8'h04
`define GPB_OFS_LATCH 8'h08
`define GPB_OFS_ANALOG 8'h0C
`define GPB_RST_DIR 4'hF
`define GPB_RST_LATCH 4'h0
`define GPB_RST_ANALOG 4'hF
`endif

// *** hw/gpb_pin_cell.sv ***
// Pin driver and digital input gating for the port
`timescale 1ns/1ps
module gpb_pin_cell
	import gpb_pkg::*;
(
	input wire gpb_pins_t pinDirectionBits,
	input wire gpb_pins_t outputLatchBits,
	input wire gpb_pins_t analogSelectBits,
	input wire gpb_pins_t padIn,
	output gpb_pins_t padOut,
	output gpb_pins_t padOe,
	output gpb_pins_t digitalIn
);
	// Analog select deliberately absent from the driver path
	assign padOe = ~pinDirectionBits; // [RULE_02] [RULE_03] [RULE_06] [RULE_08]
	assign padOut = outputLatchBits; // [RULE_03]
	assign digitalIn = padIn & ~analogSelectBits; // [RULE_07]
endmodule

// *** hw/gpb_pkg.sv ***
// Types shared by the port block
package gpb_pkg;
	typedef logic [3:0] gpb_pins_t;
	typedef enum logic [1:0] {
		GPB_REG_PORT = 2'h0,
		GPB_REG_DIR = 2'h1,
		GPB_REG_LATCH = 2'h2,
		GPB_REG_ANALOG = 2'h3
	} gpb_reg_e;
endpackage

// *** hw/gpb_port.sv ***
// Four-bit general purpose port with an AHB-Lite register slave
`timescale 1ns/1ps
`include "gpb_params.svh"
module gpb_port
	import gpb_pkg::*;
(
	input wire logic clk_sys,
	input wire logic sys_rst,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic [31:0] hrdata,
	output logic hreadyout,
	output logic hresp,
	input wire gpb_pins_t padIn,
	output gpb_pins_t padOut,
	output gpb_pins_t padOe
);
	gpb_pins_t pinDirectionBits_ff, outputLatchBits_ff, analogSelectBits_ff; // [RULE_01]
	gpb_pins_t digitalIn;
	logic wrPend_ff;
	gpb_reg_e wrReg_ff;
	logic [31:0] hrdata_ff;

	function automatic gpb_reg_e decodeReg(input logic [31:0] addr);
		return gpb_reg_e'(addr[3:2]);
	endfunction

	function automatic logic [31:0] padWord(input gpb_pins_t v);
		return {28'h0000000, v};
	endfunction

	// Unmapped addresses in the page alias nothing: only words 0..3 decode
	wire addrHit = (haddr[31:4] == 28'h0000000);
	wire accept = hsel && hready && htrans[1] && addrHit;
	wire wrAccept = accept && hwrite;
	wire rdAccept = accept && !hwrite;
	wire gpb_reg_e addrReg = decodeReg(haddr);

	gpb_pin_cell u_pin_cell (
		.pinDirectionBits(pinDirectionBits_ff),
		.outputLatchBits(outputLatchBits_ff),
		.analogSelectBits(analogSelectBits_ff),
		.padIn(padIn),
		.padOut(padOut),
		.padOe(padOe),
		.digitalIn(digitalIn)
	);

	// Read-modify-write: pins outside the write mask keep their sampled level.
	// Only whole words arrive, so the mask spans all four pins; a narrower
	// mask would store analog pins back as zero, a known hazard of the scheme
	wire gpb_pins_t wrMask = 4'hF;
	wire gpb_pins_t portMerge = (digitalIn & ~wrMask) | (hwdata[3:0] & wrMask); // [RULE_05]
	wire wrLatch = wrPend_ff && (wrReg_ff == GPB_REG_PORT || wrReg_ff == GPB_REG_LATCH);
	wire wrDir = wrPend_ff && (wrReg_ff == GPB_REG_DIR);
	wire wrAnalog = wrPend_ff && (wrReg_ff == GPB_REG_ANALOG);
	wire gpb_pins_t latchSrc = (wrReg_ff == GPB_REG_PORT) ? portMerge : hwdata[3:0];
	wire gpb_pins_t nxt_latch = wrLatch ? latchSrc : outputLatchBits_ff; // [RULE_04] [RULE_05]
	wire gpb_pins_t nxt_dir = wrDir ? hwdata[3:0] : pinDirectionBits_ff;
	wire gpb_pins_t nxt_analog = wrAnalog ? hwdata[3:0] : analogSelectBits_ff;

	wire logic [31:0] rdMux =
		(addrReg == GPB_REG_PORT) ? padWord(digitalIn) : // [RULE_04] [RULE_07]
		(addrReg == GPB_REG_DIR) ? padWord(pinDirectionBits_ff) :
		(addrReg == GPB_REG_LATCH) ? padWord(outputLatchBits_ff) : // [RULE_10]
		padWord(analogSelectBits_ff);

	// Write target held over into the data phase, where hwdata stands
	wire logic nxt_wrPend = wrAccept;
	wire gpb_reg_e nxt_wrReg = wrAccept ? addrReg : wrReg_ff;
	wire logic [31:0] nxt_hrdata = rdAccept ? rdMux : 32'h00000000;

	always_ff @(posedge clk_sys or posedge sys_rst) begin
		if (sys_rst) begin
			wrPend_ff <= 1'b0;
		end else begin
			wrPend_ff <= nxt_wrPend;
		end
	end

	always_ff @(posedge clk_sys or posedge sys_rst) begin
		if (sys_rst) begin
			wrReg_ff <= GPB_REG_PORT;
		end else begin
			wrReg_ff <= nxt_wrReg;
		end
	end

	always_ff @(posedge clk_sys or posedge sys_rst) begin
		if (sys_rst) begin
			hrdata_ff <= 32'h00000000;
		end else begin
			hrdata_ff <= nxt_hrdata;
		end
	end

	always_ff @(posedge clk_sys or posedge sys_rst) begin
		if (sys_rst) begin
			pinDirectionBits_ff <= `GPB_RST_DIR;
		end else begin
			pinDirectionBits_ff <= nxt_dir;
		end
	end

	always_ff @(posedge clk_sys or posedge sys_rst) begin
		if (sys_rst) begin
			outputLatchBits_ff <= `GPB_RST_LATCH;
		end else begin
			outputLatchBits_ff <= nxt_latch;
		end
	end

	always_ff @(posedge clk_sys or posedge sys_rst) begin
		if (sys_rst) begin
			analogSelectBits_ff <= `GPB_RST_ANALOG; // [RULE_09]
		end else begin
			analogSelectBits_ff <= nxt_analog;
		end
	end

	assign hrdata = hrdata_ff;
	assign hreadyout = 1'b1;
	assign hresp = 1'b0;

	a_drive_follows_dir: assert property (@(posedge clk_sys) // [RULE_02]
		disable iff (sys_rst) padOe == ~pinDirectionBits_ff)
		else $error("driver enable mismatch");

	a_out_is_latch: assert property (@(posedge clk_sys) // [RULE_03]
		disable iff (sys_rst) padOut == outputLatchBits_ff)
		else $error("pin output not latch");

	a_analog_reads_zero: assert property (@(posedge clk_sys) // [RULE_07]
		disable iff (sys_rst) rdAccept && addrReg == GPB_REG_PORT |=>
		(hrdata[3:0] & $past(analogSelectBits_ff)) == 4'h0)
		else $error("analog pin read nonzero");

	a_port_reads_pins: assert property (@(posedge clk_sys) // [RULE_04]
		disable iff (sys_rst) rdAccept && addrReg == GPB_REG_PORT |=>
		hrdata == {28'h0000000, $past(padIn & ~analogSelectBits_ff)})
		else $error("port read not pin level");

	a_port_write_latch: assert property (@(posedge clk_sys) // [RULE_05]
		disable iff (sys_rst) wrAccept && addrReg == GPB_REG_PORT |=>
		##1 outputLatchBits_ff == $past(hwdata[3:0]))
		else $error("port write lost");

	a_analog_keeps_drive: assert property (@(posedge clk_sys) // [RULE_06] [RULE_08]
		disable iff (sys_rst) (analogSelectBits_ff != 4'h0) |-> padOe == ~pinDirectionBits_ff)
		else $error("analog select changed driver");

	a_latch_read_back: assert property (@(posedge clk_sys) // [RULE_10]
		disable iff (sys_rst) rdAccept && addrReg == GPB_REG_LATCH |=>
		hrdata == {28'h0000000, $past(outputLatchBits_ff)})
		else $error("latch read wrong");

	a_reset_analog: assert property (@(posedge clk_sys) // [RULE_09]
		$fell(sys_rst) |-> analogSelectBits_ff == 4'hF)
		else $error("analog not set");

	a_width_four: assert property (@(posedge clk_sys) // [RULE_01]
		disable iff (sys_rst) rdAccept |=> hrdata[31:4] == 28'h0000000)
		else $error("upper bits nonzero");

	a_ready_okay: assert property (@(posedge clk_sys)
		disable iff (sys_rst) hreadyout && !hresp)
		else $error("slave not ready or not okay");

	a_idle_read_zero: assert property (@(posedge clk_sys) // [RULE_10]
		disable iff (sys_rst) !rdAccept |=> hrdata == 32'h00000000)
		else $error("read data outside read");

	a_dir_write: assert property (@(posedge clk_sys) // [RULE_02]
		disable iff (sys_rst) wrDir |=> pinDirectionBits_ff == $past(hwdata[3:0]))
		else $error("direction write lost");

	a_analog_write: assert property (@(posedge clk_sys) // [RULE_07]
		disable iff (sys_rst) wrAnalog |=> analogSelectBits_ff == $past(hwdata[3:0]))
		else $error("analog select write lost");

	a_latch_holds: assert property (@(posedge clk_sys) // [RULE_04]
		disable iff (sys_rst) !wrLatch |=> $stable(outputLatchBits_ff))
		else $error("latch changed without write");

	a_dir_holds: assert property (@(posedge clk_sys) // [RULE_02]
		disable iff (sys_rst) !wrDir |=> $stable(pinDirectionBits_ff))
		else $error("direction changed without write");

	a_analog_holds: assert property (@(posedge clk_sys) // [RULE_09]
		disable iff (sys_rst) !wrAnalog |=> $stable(analogSelectBits_ff))
		else $error("analog select changed without write");

	a_digital_in_gated: assert property (@(posedge clk_sys) // [RULE_07]
		disable iff (sys_rst) (digitalIn & analogSelectBits_ff) == 4'h0)
		else $error("analog pin seen as digital");

	a_reset_values: assert property (@(posedge clk_sys) // [RULE_09]
		$fell(sys_rst) |-> pinDirectionBits_ff == `GPB_RST_DIR &&
		outputLatchBits_ff == `GPB_RST_LATCH && hrdata == 32'h00000000)
		else $error("reset values wrong");

	a_dir_read_back: assert property (@(posedge clk_sys) // [RULE_02]
		disable iff (sys_rst) rdAccept && addrReg == GPB_REG_DIR |=>
		hrdata == {28'h0000000, $past(pinDirectionBits_ff)})
		else $error("direction read wrong");

	a_analog_read_back: assert property (@(posedge clk_sys) // [RULE_09]
		disable iff (sys_rst) rdAccept && addrReg == GPB_REG_ANALOG |=>
		hrdata == {28'h0000000, $past(analogSelectBits_ff)})
		else $error("analog select read wrong");

	c_port_write: cover property (@(posedge clk_sys) wrAccept && addrReg == GPB_REG_PORT);
	c_analog_clear: cover property (@(posedge clk_sys)
		wrPend_ff && wrReg_ff == GPB_REG_ANALOG && hwdata[3:0] == 4'h0);
	c_port_read: cover property (@(posedge clk_sys) rdAccept && addrReg == GPB_REG_PORT);
	c_analog_output: cover property (@(posedge clk_sys)
		(analogSelectBits_ff & ~pinDirectionBits_ff) != 4'h0);
	c_back_to_back: cover property (@(posedge clk_sys) wrPend_ff && accept);
endmodule

// *** testbench/four_bit_gpio_port_bench.sv ***
// Self-checking bench for the four-bit port
`timescale 1ns/1ps
module four_bit_gpio_port_bench;
	import gpb_pkg::*;
	logic clk_sys = 1'b0, sys_rst = 1'b1, hwrite = 1'b0, hready, hresp;
	logic [1:0] htrans = 2'h0;
	logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, rd;
	gpb_pins_t padOut, padOe, padIn, extDrive = 4'hC;
	int err_count = 0, n_tests = 0;
	// Row: write address, write data, read address, expected read
	logic [23:0] rows [6] = '{24'h0C00C0, 24'h04C04C, 24'h00A08A, 24'h08A00E,
		24'h0C500A, 24'h10F100};
	gpb_port i_gpb_port(.clk_sys(clk_sys), .sys_rst(sys_rst), .hsel(1'b1), .haddr(haddr),
		.htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hready),
		.hrdata(hrdata), .hreadyout(hready), .hresp(hresp), .padIn(padIn),
		.padOut(padOut), .padOe(padOe));
	gpb_pad_model i_gpb_pad_model(.padOut(padOut), .padOe(padOe), .extDrive(extDrive),
		.padIn(padIn));
	initial begin
		forever #2 clk_sys = ~clk_sys;
	end
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		n_tests++;
		if (seen !== exp) begin
			err_count++;
			$display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic xfer(input logic wr, input logic [7:0] a, input logic [3:0] d);
		htrans <= 2'h2;
		hwrite <= wr;
		haddr <= {24'h0, a};
		do @(posedge clk_sys); while (hready !== 1'b1);
		htrans <= 2'h0;
		hwdata <= {28'h0, d};
		do @(posedge clk_sys); while (hready !== 1'b1);
		rd = hrdata;
	endtask
	task automatic stop_test();
		$display("comparisons %0d mismatches %0d", n_tests, err_count);
		if (err_count == 0 && n_tests > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask
	initial begin
		repeat (12) @(posedge clk_sys);
		sys_rst <= 1'b0;
		@(posedge clk_sys);
		chk(padOe, 32'h0);
		xfer(1'b0, 8'h0C, 4'h0);
		chk(rd, 32'hF);
		chk(hresp, 32'h0);
		chk(hready, 32'h1);
		// Pins 2 and 3 stay inputs so the outside source shows in port reads
		foreach (rows[i]) begin
			xfer(1'b1, rows[i][23:16], rows[i][15:12]);
			xfer(1'b0, rows[i][11:4], 4'h0);
			chk(rd, {28'h0, rows[i][3:0]});
		end
		chk(padOe, 32'h3);
		chk(padOut, 32'hA);
		// Second reset in mid-run must restore analog mode and release drivers
		sys_rst <= 1'b1;
		@(posedge clk_sys);
		@(posedge clk_sys);
		chk(padOe, 32'h0);
		sys_rst <= 1'b0;
		@(posedge clk_sys);
		xfer(1'b0, 8'h0C, 4'h0);
		chk(rd, 32'hF);
		stop_test();
	end
	initial begin
		#40000;
		err_count++;
		stop_test();
	end
endmodule

// *** testbench/gpb_pad_model.sv ***
// Outside circuitry on the four port pins
`timescale 1ns/1ps
module gpb_pad_model
	import gpb_pkg::*;
(
	input wire gpb_pins_t padOut,
	input wire gpb_pins_t padOe,
	input wire gpb_pins_t extDrive,
	output gpb_pins_t padIn
);
	// Outside source is weak: the port driver wins wherever it is enabled
	assign padIn = (padOut & padOe) | (extDrive & ~padOe);
endmodule
